// ---- logic/ulc_pkg.sv ----
package ulc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ULC_IDX_DATA = 3'h0;
  localparam logic [2:0] ULC_IDX_DIV_HI = 3'h1;
  localparam logic [2:0] ULC_IDX_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] ULC_IDX_LINE_CONTROL = 3'h3;
  localparam logic [2:0] ULC_IDX_LINE_STATUS = 3'h5;
  localparam logic [2:0] ULC_IDX_MODE = 3'h7;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ULC_FCR_EN_BIT = 0;
  localparam int ULC_FCR_RXFL_BIT = 1;
  localparam int ULC_FCR_TXFL_BIT = 2;
  localparam int ULC_FCR_TXTRG_LSB = 4;
  localparam int ULC_FCR_RXTRG_LSB = 6;
  localparam int ULC_MODE_ENH_BIT = 0;
  localparam logic [7:0] ULC_LCR_RESET = 8'h03;
  localparam logic [15:0] ULC_DIV_RESET = 16'h0001;
  localparam logic [7:0] ULC_STAT_IDLE = 8'hc1;
  localparam logic [7:0] ULC_STAT_NOFIFO = 8'h01;

  // ---------------------------------------------------------------------------
  // Trigger thresholds, one byte per code
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ULC_TX_LVL_ENH = {8'h70, 8'h40, 8'h20, 8'h10};
  localparam logic [31:0] ULC_RX_LVL_NORM = {8'h0e, 8'h08, 8'h04, 8'h01};
  localparam logic [31:0] ULC_RX_LVL_ENH = {8'h6f, 8'h3f, 8'h1f, 8'h0f};

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ULC_OVERSAMPLE = 5'h10;
  localparam logic [4:0] ULC_HALF_BIT = 5'h08;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic stick;
    logic even;
    logic par_en;
    logic stop2;
    logic [1:0] len;
  } ulc_lcr_t;

  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic enabled;
  } ulc_fcr_t;

endpackage : ulc_pkg

// ---- logic/ulc_tx_framer.sv ----
`timescale 1ns/100ps
module ulc_tx_framer
  import ulc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [7:0] data_i,
  input wire ulc_pkg::ulc_lcr_t lcr_i,
  output logic txd_o,
  output logic busy_o
);

  typedef enum logic [2:0] {ULC_S_IDLE, ULC_S_START, ULC_S_DATA, ULC_S_PAR, ULC_S_STOP} ulc_state_t;

  ulc_state_t state;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [4:0] sub_cnt;
  logic stop_half;
  logic parity;
  logic [7:0] mask;
  logic bit_done;

  assign mask = 8'hff >> (3'h3 - {1'b0, lcr_i.len});
  assign bit_done = tick_i && (sub_cnt == ULC_OVERSAMPLE - 5'h1);

  // ---------------------------------------------------------------------------
  // Character framing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ULC_S_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      sub_cnt <= 5'h00;
      stop_half <= 1'b0;
      parity <= 1'b0;
      txd_o <= 1'b1;
      busy_o <= 1'b0;
    end
    else
    begin
      if (tick_i && state != ULC_S_IDLE)
        sub_cnt <= bit_done ? 5'h00 : sub_cnt + 5'h1;
      case (state)
        ULC_S_IDLE:
        begin
          txd_o <= 1'b1;
          busy_o <= start_i;
          if (start_i)
          begin
            shift <= data_i & mask;
            // Odd parity sets the bit when the data has an even count of ones.
            parity <= lcr_i.stick ? ~lcr_i.even : (^(data_i & mask)) ^ ~lcr_i.even;
            sub_cnt <= 5'h00;
            txd_o <= 1'b0;
            state <= ULC_S_START;
          end
        end
        ULC_S_START:
          if (bit_done)
          begin
            txd_o <= shift[0];
            bit_cnt <= 3'h0;
            state <= ULC_S_DATA;
          end
        ULC_S_DATA:
          if (bit_done)
          begin
            shift <= shift >> 1;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == {1'b0, lcr_i.len} + 3'h4)
            begin
              txd_o <= lcr_i.par_en ? parity : 1'b1;
              stop_half <= 1'b0;
              state <= lcr_i.par_en ? ULC_S_PAR : ULC_S_STOP;
            end
            else
              txd_o <= shift[1];
          end
        ULC_S_PAR:
          if (bit_done)
          begin
            txd_o <= 1'b1;
            state <= ULC_S_STOP;
          end
        ULC_S_STOP:
          // One stop bit, or with stop2 set 1.5 for 5-bit characters and 2 for longer ones.
          // The stop_half flag marks the extra stop period, half a bit long for 5-bit characters.
          if (stop_half && lcr_i.len == 2'h0 && tick_i && sub_cnt == ULC_HALF_BIT - 5'h1)
          begin
            state <= ULC_S_IDLE;
            busy_o <= 1'b0;
          end
          else if (bit_done)
          begin
            if (lcr_i.stop2 && !stop_half)
              stop_half <= 1'b1;
            else
            begin
              state <= ULC_S_IDLE;
              busy_o <= 1'b0;
            end
          end
        default:
          state <= ULC_S_IDLE;
      endcase
    end
  end

  start_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ULC_S_IDLE && start_i) |=> !txd_o && state == ULC_S_START)
    else $error("Start bit not driven low.");

endmodule : ulc_tx_framer

// ---- logic/ulc_top.sv ----
`timescale 1ns/100ps
module ulc_top
  import ulc_pkg::*;
#(
  parameter int DEPTH = 128
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic txd_o,
  output logic tx_trig_o,
  output logic rx_trig_o
);
  import ulc_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;
  localparam int AW = $clog2(DEPTH);

  ulc_lcr_t line_control;
  ulc_fcr_t fifo_control;
  logic enh;
  logic rx_flush;
  logic tx_flush;
  logic [15:0] divisor;
  logic [15:0] div_cnt;
  logic tick;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_rd;
  logic [AW-1:0] tx_wr;
  logic [AW-1:0] rx_rd;
  logic [AW-1:0] rx_wr;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] cap;
  logic [2:0] idx;
  logic wr_go;
  logic rd_go;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic ser_txd;
  logic ser_busy;
  logic [7:0] tx_lvl;
  logic [7:0] rx_lvl;
  logic [7:0] next_rdata;

  assign idx = adr_i[4:2];
  assign wr_go = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign rd_go = cyc_i && stb_i && ack_o && !we_i;
  // With the FIFOs off each direction holds a single character.
  assign cap = fifo_control.enabled ? CW'(DEPTH) : CW'(1);
  assign tx_push = wr_go && idx == ULC_IDX_DATA && !line_control.dlab && tx_cnt != cap;
  assign tx_pop = !ser_busy && tx_cnt != '0 && !line_control.brk && !tx_flush;
  assign rx_push = rx_valid_i && rx_cnt != cap && !rx_flush;
  assign rx_pop = rd_go && idx == ULC_IDX_DATA && !line_control.dlab && rx_cnt != '0;
  assign tx_lvl = ULC_TX_LVL_ENH[8*fifo_control.tx_trig +: 8];
  assign rx_lvl = enh ? ULC_RX_LVL_ENH[8*fifo_control.rx_trig +: 8] : ULC_RX_LVL_NORM[8*fifo_control.rx_trig +: 8];
  assign tick = div_cnt == '0;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    case (idx)
      ULC_IDX_DATA: next_rdata = line_control.dlab ? divisor[7:0] : rx_mem[rx_rd];
      ULC_IDX_DIV_HI: next_rdata = line_control.dlab ? divisor[15:8] : 8'h00;
      ULC_IDX_FIFO_CONTROL: next_rdata = fifo_control.enabled ? ULC_STAT_IDLE : ULC_STAT_NOFIFO;
      ULC_IDX_LINE_CONTROL: next_rdata = line_control;
      ULC_IDX_LINE_STATUS: next_rdata = {1'b0, tx_cnt == '0 && !ser_busy, tx_cnt == '0, 4'h0, rx_cnt != '0};
      ULC_IDX_MODE: next_rdata = {7'h00, enh};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= {24'h000000, next_rdata};
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_control <= ULC_LCR_RESET;
      fifo_control <= '0;
      enh <= 1'b0;
      divisor <= ULC_DIV_RESET;
    end
    else if (wr_go)
    begin
      if (idx == ULC_IDX_LINE_CONTROL)
        line_control <= dat_i[7:0];
      if (idx == ULC_IDX_MODE)
        enh <= dat_i[ULC_MODE_ENH_BIT];
      if (idx == ULC_IDX_DATA && line_control.dlab)
        divisor[7:0] <= dat_i[7:0];
      if (idx == ULC_IDX_DIV_HI && line_control.dlab)
        divisor[15:8] <= dat_i[7:0];
      if (idx == ULC_IDX_FIFO_CONTROL && !line_control.dlab)
        fifo_control <= {dat_i[ULC_FCR_RXTRG_LSB +: 2], dat_i[ULC_FCR_TXTRG_LSB +: 2], dat_i[ULC_FCR_EN_BIT]};
    end
  end

  // Flush flags live for one cycle, empty their FIFO, then clear themselves.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
    end
    else
    begin
      rx_flush <= wr_go && idx == ULC_IDX_FIFO_CONTROL && !line_control.dlab && dat_i[ULC_FCR_RXFL_BIT];
      tx_flush <= wr_go && idx == ULC_IDX_FIFO_CONTROL && !line_control.dlab && dat_i[ULC_FCR_TXFL_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (tx_push)
      tx_mem[tx_wr] <= dat_i[7:0];
    if (rx_push)
      rx_mem[rx_wr] <= rx_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tx_flush)
    begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      tx_wr <= tx_wr + AW'(tx_push);
      tx_rd <= tx_rd + AW'(tx_pop);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || rx_flush)
    begin
      rx_rd <= '0;
      rx_wr <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      rx_wr <= rx_wr + AW'(rx_push);
      rx_rd <= rx_rd + AW'(rx_pop);
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // ---------------------------------------------------------------------------
  // Triggers, baud tick and line output
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_trig_o <= 1'b0;
      rx_trig_o <= 1'b0;
    end
    else
    begin
      tx_trig_o <= (fifo_control.enabled && enh) ? tx_cnt < CW'(tx_lvl) : tx_cnt == '0;
      rx_trig_o <= fifo_control.enabled ? rx_cnt >= CW'(rx_lvl) : rx_cnt != '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      div_cnt <= (divisor == '0) ? 16'h0000 : divisor - 16'h1;
    else
      div_cnt <= div_cnt - 16'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      txd_o <= 1'b1;
    else
      txd_o <= ser_txd && !line_control.brk;
  end

  ulc_tx_framer u_framer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .start_i(tx_pop),
    .data_i(tx_mem[tx_rd]),
    .lcr_i(line_control),
    .txd_o(ser_txd),
    .busy_o(ser_busy)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  fifo_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && idx == ULC_IDX_FIFO_CONTROL && !line_control.dlab) |=> fifo_control.enabled == $past(dat_i[0]))
    else $error("FIFO enable did not follow the write.");

  rx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_flush |=> rx_cnt == '0 && !rx_flush ##1 !rx_flush)
    else $error("Receive flush did not empty or clear.");

  tx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_flush |=> tx_cnt == '0 && !tx_flush)
    else $error("Transmit flush did not empty or clear.");

  tx_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fifo_control.enabled && enh && fifo_control.tx_trig == 2'h3 && tx_cnt == CW'(111)) |=> tx_trig_o)
    else $error("Transmit trigger at wrong level.");

  rx_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fifo_control.enabled && !enh && fifo_control.rx_trig == 2'h3) |=> rx_trig_o == ($past(rx_cnt) >= CW'(14)))
    else $error("Receive trigger at wrong level.");

  break_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_control.brk [*2] |-> !txd_o && !tx_pop)
    else $error("Break did not hold the line at space.");

  divisor_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && idx == ULC_IDX_DATA && line_control.dlab) |=> divisor[7:0] == $past(dat_i[7:0]) && $stable(tx_wr))
    else $error("Divisor latch access reached the data path.");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("Acknowledge timing wrong.");

endmodule : ulc_top

// ---- testbench/ulc_remote_model.sv ----
`timescale 1ns/100ps
module ulc_remote_model
  import ulc_pkg::*;
#(
  parameter int BIT_CLKS = 16
)
(
  input wire logic clk_i,
  input wire logic txd_i,
  input wire ulc_pkg::ulc_lcr_t lcr_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic got_o,
  output logic [7:0] got_data_o,
  output logic got_par_o,
  output logic stop_ok_o
);
  import ulc_pkg::*;
  int i;
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    got_data_o = 8'h00;
    got_par_o = 1'b0;
    stop_ok_o = 1'b0;
  end
  // Samples each frame at bit centres using the framing the bench announces.
  always
  begin
    got_o <= 1'b0;
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    got_data_o <= 8'h00;
    for (i = 0; i < 5 + int'(lcr_i.len); i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got_data_o[i] <= txd_i;
    end
    if (lcr_i.par_en)
    begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got_par_o <= txd_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    stop_ok_o <= txd_i;
    got_o <= 1'b1;
    @(posedge clk_i);
  end
  // Hands over a received character; the data lines show garbage when idle.
  task automatic send(input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask : send
endmodule : ulc_remote_model

// ---- testbench/ulc_top_tb_top.sv ----
`timescale 1ns/100ps
module ulc_top_tb_top;
  import ulc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [4:0] adr_i = 0;
  logic [3:0] sel_i = 0, wsel = 4'hf;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic ack_o, rx_valid_i, txd_o, tx_trig_o, rx_trig_o, got, got_par, stop_ok;
  logic [7:0] rx_data_i, got_data, b, p, bm;
  ulc_lcr_t frame_lcr = ULC_LCR_RESET;
  int errors = 0, n_checks = 0, seed = 23516, k, n, c, m;
  int rxq[$];
  int rx_norm[4] = '{1, 4, 8, 14};
  int rx_enh[4] = '{15, 31, 63, 111};
  int tx_enh[4] = '{16, 32, 64, 112};
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  ulc_top #(.DEPTH(128)) u_ulc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .txd_o(txd_o), .tx_trig_o(tx_trig_o),
    .rx_trig_o(rx_trig_o));
  ulc_remote_model #(.BIT_CLKS(16)) u_ulc_remote_model (.clk_i(clk_i), .txd_i(txd_o),
    .lcr_i(frame_lcr), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .got_o(got),
    .got_data_o(got_data), .got_par_o(got_par), .stop_ok_o(stop_ok));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wb(input logic w, input logic [2:0] idx, input logic [7:0] wd);
    int t;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= wsel;
    dat_i <= {24'h0, wd};
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (ack_o !== 1'b1 && t < 50);
    if (t >= 50)
    begin
      errors++;
    end
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask : wb
  task push(input int cnt);
    repeat (cnt)
    begin
      b = $random(seed);
      u_ulc_remote_model.send(b, 1);
      rxq.push_back(b);
    end
  endtask : push
  task wr_rand(input int cnt);
    repeat (cnt)
    begin
      b = $random(seed);
      wb(1, ULC_IDX_DATA, b);
    end
  endtask : wr_rand
  task settle;
    repeat (4) @(posedge clk_i);
  endtask : settle
  task test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (40000) @(posedge clk_i);
    errors++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wb(0, ULC_IDX_LINE_CONTROL, 0);
    chk("lcr reset", 32'h03, rd);
    wb(0, ULC_IDX_FIFO_CONTROL, 0);
    chk("fifo off", {24'h0, ULC_STAT_NOFIFO}, rd);
    wb(0, 3'h4, 0);
    chk("unmapped", 0, rd);
    wsel = 4'he;
    wb(1, ULC_IDX_LINE_CONTROL, 8'h80);
    wsel = 4'hf;
    wb(0, ULC_IDX_LINE_CONTROL, 0);
    chk("masked write", 32'h03, rd);
    push(2);
    settle();
    wb(0, ULC_IDX_DATA, 0);
    chk("single hold", rxq[0], rd);
    wb(0, ULC_IDX_LINE_STATUS, 0);
    chk("rx empty", 0, rd[0]);
    rxq.delete();
    wb(1, ULC_IDX_LINE_CONTROL, 8'h83);
    wb(1, ULC_IDX_DATA, 8'h5a);
    wb(1, ULC_IDX_DIV_HI, 8'h00);
    wb(0, ULC_IDX_DATA, 0);
    chk("div low", 32'h5a, rd);
    wb(1, ULC_IDX_DATA, 8'h01);
    wb(1, ULC_IDX_LINE_CONTROL, 8'h03);
    wb(0, ULC_IDX_DIV_HI, 0);
    chk("div hidden", 0, rd);
    wb(0, ULC_IDX_LINE_STATUS, 0);
    chk("no tx push", 1, rd[5]);
    $display("test reset and map done");
    wb(1, ULC_IDX_FIFO_CONTROL, 8'h07);
    push(3);
    settle();
    for (k = 0; k < 3; k++)
    begin
      wb(0, ULC_IDX_DATA, 0);
      chk("rx order", rxq.pop_front(), rd);
    end
    wb(0, ULC_IDX_FIFO_CONTROL, 0);
    chk("fifo on", {24'h0, ULC_STAT_IDLE}, rd);
    for (m = 0; m < 2; m++)
    begin
      wb(1, ULC_IDX_MODE, m[7:0]);
      for (c = 0; c < 4; c++)
      begin
        n = m ? rx_enh[c] : rx_norm[c];
        wb(1, ULC_IDX_FIFO_CONTROL, {c[1:0], 6'h03});
        push(n - 1);
        settle();
        chk("rx below", 0, rx_trig_o);
        push(1);
        settle();
        chk("rx reached", 1, rx_trig_o);
      end
    end
    wb(1, ULC_IDX_FIFO_CONTROL, 8'h01);
    settle();
    chk("rx no flush", 1, rx_trig_o);
    wb(1, ULC_IDX_FIFO_CONTROL, 8'h03);
    settle();
    chk("rx flushed", 0, rx_trig_o);
    wb(0, ULC_IDX_LINE_STATUS, 0);
    chk("rx flush status", 0, rd[0]);
    rxq.delete();
    $display("test rx trigger done");
    wb(1, ULC_IDX_LINE_CONTROL, 8'h43);
    settle();
    chk("break low", 0, txd_o);
    for (c = 0; c < 4; c++)
    begin
      wb(1, ULC_IDX_FIFO_CONTROL, {2'b00, c[1:0], 4'h5});
      settle();
      chk("tx empty trig", 1, tx_trig_o);
      wr_rand(tx_enh[c] - 1);
      settle();
      chk("tx below", 1, tx_trig_o);
      wr_rand(1);
      settle();
      chk("tx reached", 0, tx_trig_o);
      chk("break held", 0, txd_o);
    end
    wb(1, ULC_IDX_FIFO_CONTROL, 8'h01);
    settle();
    chk("tx no flush", 0, tx_trig_o);
    wb(1, ULC_IDX_FIFO_CONTROL, 8'h05);
    settle();
    chk("tx flushed", 1, tx_trig_o);
    wb(0, ULC_IDX_LINE_STATUS, 0);
    chk("tx flush status", 1, rd[5]);
    wb(1, ULC_IDX_LINE_CONTROL, 8'h03);
    repeat (80) @(posedge clk_i);
    chk("idle high", 1, txd_o);
    wb(1, ULC_IDX_MODE, 0);
    $display("test tx trigger and break done");
    repeat (10)
    begin
      b = $random(seed);
      p = $random(seed);
      frame_lcr <= ulc_lcr_t'({2'b00, p[5:0]});
      wb(1, ULC_IDX_LINE_CONTROL, {2'b00, p[5:0]});
      wb(1, ULC_IDX_DATA, b);
      bm = b & (8'hff >> (3 - p[1:0]));
      k = 0;
      while (got !== 1'b1 && k < 400)
      begin
        @(posedge clk_i);
        k++;
      end
      chk("frame seen", 1, got);
      chk("frame data", bm, got_data);
      chk("frame stop", 1, stop_ok);
      if (p[3])
        chk("frame parity", p[5] ? ~p[4] : (p[4] ? ^bm : ~^bm), got_par);
      repeat (64) @(posedge clk_i);
    end
    $display("test framing done");
    test_done();
  end
endmodule : ulc_top_tb_top
